// ===== ceh_top.sv
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ceh_top (
	// clock, reset, enable
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	// register port
	input wire logic [ceh_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// event sources and core requests
	input wire ceh_pkg::ceh_evt_s evt,
	input wire ceh_pkg::ceh_irq_s irq,
	input wire ceh_pkg::ceh_ctl_s ctl,
	input wire ceh_pkg::ceh_ctx_s ctx,
	// acceptance
	output logic evt_ack,
	output logic [3:0] evt_ack_idx,
	output logic irq_ack,
	output logic [1:0] irq_ack_lvl,
	output logic busy,
	// system stack port
	output ceh_pkg::ceh_stk_s stk,
	input wire logic [31:0] stk_rdata,
	// core side
	output ceh_pkg::ceh_rf_s rf,
	output ceh_pkg::ceh_pc_s pc,
	output logic [31:0] sr,
	output logic [2:0] bank_sel
);
	import ceh_pkg::*;

	logic rst_meta;
	logic rst_n_s;
	ceh_state_s s_r;
	ceh_state_s s_nxt;
	logic [EXC_N-1:0] exc_src;
	logic [EV_N-1:0] pend;
	logic [EV_N-1:0] elig;
	logic [2:0] cur_mode;
	logic sel_ok;
	logic [3:0] sel_idx;
	logic [2:0] sel_mode;
	logic sel_int;
	logic [AV_W-1:0] sel_off;

	// reset release
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n_s <= rst_meta;
		end
	end

	// priority rank of a mode
	function automatic logic [2:0] rank(input logic [2:0] m);
		logic [2:0] r;
		r = 3'h0;
		if (m == MODE_NMI) begin
			r = 3'h6;
		end else if (m == MODE_EXC) begin
			r = 3'h5;
		end else if (m >= MODE_INTERRUPT_LEVEL_0) begin
			r = 3'(m - 3'h1);
		end
		return r;
	endfunction : rank

	function automatic logic is_int_mode(input logic [2:0] m);
		return (m >= MODE_INTERRUPT_LEVEL_0) && (m <= MODE_INTERRUPT_LEVEL_3);
	endfunction : is_int_mode

	// mask test for an event class
	function automatic logic mask_hit(input logic [2:0] m, input logic [31:0] v);
		logic h;
		h = 1'b0;
		if (m == MODE_EXC) begin
			h = v[SR_EM];
		end else if (is_int_mode(m)) begin
			h = v[SR_GM] | v[SR_I0M + int'(m - MODE_INTERRUPT_LEVEL_0)];
		end
		return h;
	endfunction : mask_hit

	// masks of equal and lower priority sources
	function automatic logic [31:0] mask_set(input logic [2:0] m);
		logic [31:0] v;
		v = '0;
		for (int i = 0; i < 4; i++) begin
			if (!is_int_mode(m) || (i <= int'(m - MODE_INTERRUPT_LEVEL_0))) begin
				v[SR_I0M + i] = 1'b1;
			end
		end
		if (!is_int_mode(m)) begin
			v[SR_EM] = 1'b1;
			v[SR_GM] = 1'b1;
		end
		return v;
	endfunction : mask_set

	function automatic logic [31:0] with_mode(input logic [31:0] v, input logic [2:0] m);
		logic [31:0] r;
		r = v;
		r[SR_MODE +: 3] = m;
		return r;
	endfunction : with_mode

	assign cur_mode = s_r.sr[SR_MODE +: 3];

	// [RQ19] oldest instruction first
	assign exc_src = (|evt.exc_old) ? evt.exc_old : evt.exc_young;
	assign pend = {exc_src[10:3], irq.req[0], irq.req[1], irq.req[2], irq.req[3], evt.nmi, exc_src[2:0]};

	// per slot acceptance test
	genvar gi;
	for (gi = 0; gi < EV_N; gi++) begin : g_elig
		logic crit;
		logic masked;
		logic above;
		assign crit = EV_CRIT[gi];
		// [RQ6] masked not accepted
		// [RQ7] critical bypass masks
		assign masked = !crit && mask_hit(EV_MODE[gi], s_r.sr);
		// [RQ1] only higher class preempts, critical events also preempt an equal class
		assign above = (rank(EV_MODE[gi]) > rank(cur_mode)) ||
			(crit && (rank(EV_MODE[gi]) == rank(cur_mode)));
		assign elig[gi] = pend[gi] && !masked && above;
	end

	// [RQ18] fixed priority pick
	always_comb begin
		sel_ok = 1'b0;
		sel_idx = '0;
		for (int i = EV_N - 1; i >= 0; i--) begin
			if (elig[i]) begin
				sel_ok = 1'b1;
				sel_idx = 4'(i);
			end
		end
	end

	assign sel_mode = EV_MODE[sel_idx];
	assign sel_int = is_int_mode(sel_mode);
	// [RQ4] autovector offset width
	// [RQ22] offset sampled on acceptance
	assign sel_off = sel_int ? irq.offset : EV_OFF[sel_idx];

	always_comb begin
		s_nxt = s_r;
		s_nxt.stk.we = 1'b0;
		s_nxt.stk.re = 1'b0;
		s_nxt.rf.we = 1'b0;
		s_nxt.pc.load = 1'b0;
		s_nxt.ack = 1'b0;
		s_nxt.irq_ack = 1'b0;
		s_nxt.rdata = '0;

		// register port
		if (reg_rd) begin
			if (reg_addr == REG_EVENT_VECTOR_BASE) begin
				s_nxt.rdata = s_r.event_vector_base;
			end else if (reg_addr == REG_SR) begin
				s_nxt.rdata = s_r.sr;
			end else if (reg_addr == REG_SP) begin
				s_nxt.rdata = s_r.sp;
			end else if (reg_addr == REG_DRAR) begin
				s_nxt.rdata = s_r.dbg_rar;
			end else if (reg_addr == REG_DRSR) begin
				s_nxt.rdata = s_r.dbg_rsr;
			end
		end
		if (reg_wr) begin
			if (reg_addr == REG_EVENT_VECTOR_BASE) begin
				s_nxt.event_vector_base = reg_wdata;
			end else if (reg_addr == REG_SR) begin
				// [RQ16] free mode change in debug
				s_nxt.sr = reg_wdata;
			end else if (reg_addr == REG_SP) begin
				s_nxt.sp = reg_wdata;
			end else if (reg_addr == REG_DRAR) begin
				s_nxt.dbg_rar = reg_wdata;
			end else if (reg_addr == REG_DRSR) begin
				s_nxt.dbg_rsr = reg_wdata;
			end
		end

		// [RQ17] fetch from reset address
		if (!s_r.boot) begin
			s_nxt.boot = 1'b1;
			s_nxt.pc.load = 1'b1;
			s_nxt.pc.target = RESET_ADDR;
		end

		unique case (s_r.st)
			ST_IDLE: begin
				if (!s_r.boot) begin
					s_nxt.st = ST_IDLE;
				end else if (ctl.dbg_req && !s_r.sr[SR_DM] && !s_r.sr[SR_D]) begin
					// [RQ15] debug entry
					s_nxt.dbg_rar = ctx.ctx_pc;
					s_nxt.dbg_rsr = s_r.sr;
					s_nxt.sr = with_mode(s_r.sr | mask_set(MODE_EXC), MODE_EXC);
					s_nxt.sr[SR_D] = 1'b1;
					s_nxt.pc.load = 1'b1;
					s_nxt.pc.target = ctl.dbg_addr;
				end else if (sel_ok) begin
					s_nxt.ack = 1'b1;
					s_nxt.ack_idx = sel_idx;
					s_nxt.irq_ack = sel_int;
					s_nxt.irq_lvl = 2'(sel_mode - MODE_INTERRUPT_LEVEL_0);
					s_nxt.old_sr = s_r.sr;
					// [RQ8] set equal and lower masks
					// [RQ11] exceptions set em and gm
					s_nxt.new_sr = with_mode(s_r.sr | mask_set(sel_mode), sel_mode);
					// [RQ20] offending or next pc
					// [RQ21] next pc saved
					s_nxt.save_pc = EV_OFFEND[sel_idx] ? ctx.off_pc : ctx.ctx_pc;
					// [RQ2] spaced handler offsets
					// [RQ3] base or offset
					s_nxt.target = s_r.event_vector_base | {{(32 - AV_W){1'b0}}, sel_off};
					s_nxt.k = '0;
					s_nxt.last = sel_int ? PUSH_LAST_INT : PUSH_LAST_EXC;
					s_nxt.st = ST_PUSH;
				end else if (ctl.retd && s_r.sr[SR_D]) begin
					// [RQ16] restore from debug registers
					s_nxt.sr = s_r.dbg_rsr;
					s_nxt.pc.load = 1'b1;
					s_nxt.pc.target = s_r.dbg_rar;
				end else if (ctl.rete) begin
					// [RQ13] pop count by mode
					s_nxt.k = is_int_mode(cur_mode) ? PUSH_LAST_INT : PUSH_LAST_EXC;
					s_nxt.st = ST_POP_RD;
				end else if (ctl.rets) begin
					// [RQ14] return via stack
					s_nxt.k = PUSH_LAST_EXC;
					s_nxt.st = ST_POP_RD;
				end else if (ctl.scall) begin
					// [RQ14] call via stack
					s_nxt.old_sr = s_r.sr;
					s_nxt.new_sr = with_mode(s_r.sr, MODE_SUP);
					s_nxt.save_pc = 32'(ctx.ctx_pc + 32'h0000_0002);
					s_nxt.target = s_r.event_vector_base | {{(32 - AV_W){1'b0}}, SCALL_OFF};
					s_nxt.k = '0;
					s_nxt.last = PUSH_LAST_EXC;
					s_nxt.st = ST_PUSH;
				end
			end
			ST_PUSH: begin
				// [RQ10] push context words
				s_nxt.sp = 32'(s_r.sp - WORD_BYTES);
				s_nxt.stk.addr = 32'(s_r.sp - WORD_BYTES);
				s_nxt.stk.we = 1'b1;
				if (s_r.k == 3'h0) begin
					s_nxt.stk.wdata = s_r.save_pc;
				end else if (s_r.k == 3'h1) begin
					s_nxt.stk.wdata = s_r.old_sr;
				end else begin
					s_nxt.stk.wdata = ctx.regs[3'(s_r.k - 3'h2)];
				end
				if (s_r.k == s_r.last) begin
					s_nxt.st = ST_VEC;
				end else begin
					s_nxt.k = 3'(s_r.k + 3'h1);
				end
			end
			ST_VEC: begin
				// [RQ12] mode, bank, handler
				s_nxt.sr = s_r.new_sr;
				s_nxt.pc.load = 1'b1;
				s_nxt.pc.target = s_r.target;
				s_nxt.st = ST_IDLE;
			end
			ST_POP_RD: begin
				s_nxt.stk.re = 1'b1;
				s_nxt.stk.addr = s_r.sp;
				s_nxt.sp = 32'(s_r.sp + WORD_BYTES);
				s_nxt.st = ST_POP_WT;
			end
			ST_POP_WT: begin
				// [RQ13] restore popped words
				if (s_r.k == 3'h0) begin
					s_nxt.pc.load = 1'b1;
					s_nxt.pc.target = stk_rdata;
					s_nxt.st = ST_IDLE;
				end else begin
					if (s_r.k == 3'h1) begin
						s_nxt.sr = stk_rdata;
					end else begin
						s_nxt.rf.we = 1'b1;
						s_nxt.rf.idx = 3'(s_r.k - 3'h2);
						s_nxt.rf.data = stk_rdata;
					end
					s_nxt.k = 3'(s_r.k - 3'h1);
					s_nxt.st = ST_POP_RD;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n_s) begin
		if (!rst_n_s) begin
			s_r <= STATE_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign evt_ack = s_r.ack;
	assign evt_ack_idx = s_r.ack_idx;
	assign irq_ack = s_r.irq_ack;
	assign irq_ack_lvl = s_r.irq_lvl;
	assign busy = (s_r.st != ST_IDLE) || !s_r.boot;
	assign stk = s_r.stk;
	assign rf = s_r.rf;
	assign pc = s_r.pc;
	assign sr = s_r.sr;
	assign bank_sel = s_r.sr[SR_MODE +: 3];
endmodule : ceh_top
`default_nettype wire

// ===== ceh_pkg.sv
// Contract
// [RQ1] higher priority class may preempt a lower one, never the reverse
// [RQ2] handlers sit four bytes apart from the base, a few more widely spaced
// [RQ3] handler address is base OR offset, never base plus offset
// [RQ4] autovector offset is 14 bits, reaching at most 16384 bytes
// [RQ5] interrupt controller resolves priority and supplies the chosen autovector
// [RQ6] masked pending events are not accepted
// [RQ7] nmi, unrecoverable and bus error events ignore every mask bit
// [RQ8] acceptance sets masks of all equal or lower priority sources
// [RQ9] every source holds its request until the cpu accepts it
// [RQ10] acceptance pushes status and pc, interrupts also r8-r12 and link register
// [RQ11] accepted exceptions set exception mask and global interrupt mask
// [RQ12] after saving, set mode, select bank, load handler address
// [RQ13] return from event pops status and pc, interrupts also r8-r12 and lr
// [RQ14] supervisor call and its return use the system stack
// [RQ15] debug request enters debug unless debug mask set; sets flag, jumps
// [RQ16] debug uses dedicated return registers, return from debug restores context
// [RQ17] reset starts fetching at 0x80000000
// [RQ18] same-instruction events are served in fixed table priority
// [RQ19] oldest instruction events go before any younger instruction events
// [RQ20] unrecoverable to 0x00 saving offending pc; data bus error to 0x08
// [RQ21] instruction bus error to 0x0C, nmi to 0x10, both save next pc
// [RQ22] controller holds level and offset stable; cpu samples them on acceptance
package ceh_pkg;
	localparam int AV_W = 14;
	localparam int EV_N = 16;
	localparam int EXC_N = 11;
	localparam int REG_AW = 5;
	localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] SR_RST = 32'h0061_0000;
	localparam logic [31:0] SP_RST = 32'h0000_0000;
	localparam logic [31:0] EVENT_VECTOR_BASE_RST = 32'h0000_0000;
	localparam logic [AV_W-1:0] SCALL_OFF = 14'h0100;
	// status register layout
	localparam int SR_GM = 16;
	localparam int SR_I0M = 17;
	localparam int SR_EM = 21;
	localparam int SR_MODE = 22;
	localparam int SR_DM = 25;
	localparam int SR_D = 26;
	// execution modes
	localparam logic [2:0] MODE_APP = 3'h0;
	localparam logic [2:0] MODE_SUP = 3'h1;
	localparam logic [2:0] MODE_INTERRUPT_LEVEL_0 = 3'h2;
	localparam logic [2:0] MODE_INTERRUPT_LEVEL_3 = 3'h5;
	localparam logic [2:0] MODE_EXC = 3'h6;
	localparam logic [2:0] MODE_NMI = 3'h7;
	// register port offsets
	localparam logic [REG_AW-1:0] REG_EVENT_VECTOR_BASE = 5'h00;
	localparam logic [REG_AW-1:0] REG_SR = 5'h04;
	localparam logic [REG_AW-1:0] REG_SP = 5'h08;
	localparam logic [REG_AW-1:0] REG_DRAR = 5'h0C;
	localparam logic [REG_AW-1:0] REG_DRSR = 5'h10;
	// event slots, index 0 highest priority
	localparam logic [2:0] EV_MODE [EV_N] = '{3'h6, 3'h6, 3'h6, 3'h7, 3'h5, 3'h4, 3'h3, 3'h2,
		3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6};
	localparam logic [AV_W-1:0] EV_OFF [EV_N] = '{14'h0000, 14'h0008, 14'h000C, 14'h0010,
		14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0014, 14'h001C, 14'h0020, 14'h0024,
		14'h0028, 14'h0030, 14'h0034, 14'h0038};
	localparam logic [EV_N-1:0] EV_CRIT = 16'h000F;
	localparam logic [EV_N-1:0] EV_OFFEND = 16'hFD01;
	localparam logic [2:0] PUSH_LAST_INT = 3'h7;
	localparam logic [2:0] PUSH_LAST_EXC = 3'h1;

	typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_VEC, ST_POP_RD, ST_POP_WT} ceh_st_e;
	typedef struct packed {logic [EXC_N-1:0] exc_old; logic [EXC_N-1:0] exc_young; logic nmi;} ceh_evt_s;
	typedef struct packed {logic [3:0] req; logic [AV_W-1:0] offset;} ceh_irq_s;
	typedef struct packed {logic dbg_req; logic [31:0] dbg_addr; logic scall; logic rets; logic rete;
		logic retd;} ceh_ctl_s;
	typedef struct packed {logic [31:0] ctx_pc; logic [31:0] off_pc; logic [5:0][31:0] regs;} ceh_ctx_s;
	typedef struct packed {logic [31:0] addr; logic [31:0] wdata; logic we; logic re;} ceh_stk_s;
	typedef struct packed {logic we; logic [2:0] idx; logic [31:0] data;} ceh_rf_s;
	typedef struct packed {logic load; logic [31:0] target;} ceh_pc_s;
	typedef struct packed {
		ceh_st_e st;
		logic [31:0] sr;
		logic [31:0] event_vector_base;
		logic [31:0] sp;
		logic [31:0] dbg_rar;
		logic [31:0] dbg_rsr;
		logic [31:0] old_sr;
		logic [31:0] new_sr;
		logic [31:0] save_pc;
		logic [31:0] target;
		logic [31:0] rdata;
		logic [2:0] k;
		logic [2:0] last;
		logic boot;
		ceh_stk_s stk;
		ceh_rf_s rf;
		ceh_pc_s pc;
		logic ack;
		logic [3:0] ack_idx;
		logic irq_ack;
		logic [1:0] irq_lvl;
	} ceh_state_s;
	localparam ceh_state_s STATE_RST = '{st: ST_IDLE, sr: SR_RST, sp: SP_RST, event_vector_base: EVENT_VECTOR_BASE_RST, default: '0};
endpackage : ceh_pkg

// ===== ceh_irqc_model.sv
`timescale 1ns/1ps
`default_nettype none
module ceh_irqc_model (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// new requests and acceptance
	input wire logic [3:0] want,
	input wire logic irq_ack,
	input wire logic [1:0] irq_ack_lvl,
	// request to the cpu
	output var ceh_pkg::ceh_irq_s irq
);
	import ceh_pkg::*;
	logic [3:0] req_r;
	logic [1:0] top;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			req_r <= 4'h0;
		end else begin
			req_r <= (req_r & ~(irq_ack ? 4'h1 << irq_ack_lvl : 4'h0)) | want;
		end
	end
	always_comb begin
		top = req_r[3] ? 2'h3 : req_r[2] ? 2'h2 : req_r[1] ? 2'h1 : 2'h0;
		irq.req = req_r;
		irq.offset = (top == 2'h3) ? 14'h3FFC : {top, 12'h104};
	end
endmodule : ceh_irqc_model
`default_nettype wire

// ===== ceh_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ceh_top_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// inputs
	input wire logic ce,
	input wire logic [ceh_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire ceh_pkg::ceh_evt_s evt,
	input wire ceh_pkg::ceh_irq_s irq,
	input wire ceh_pkg::ceh_ctl_s ctl,
	// outputs
	input wire logic evt_ack,
	input wire logic [3:0] evt_ack_idx,
	input wire logic irq_ack,
	input wire logic busy,
	input wire ceh_pkg::ceh_stk_s stk,
	input wire ceh_pkg::ceh_pc_s pc,
	input wire logic [31:0] sr
);
	import ceh_pkg::*;
	logic [31:0] event_vector_base_r;
	logic boot_r;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			event_vector_base_r <= EVENT_VECTOR_BASE_RST;
			boot_r <= 1'b1;
		end else begin
			if (ce && reg_wr && reg_addr == REG_EVENT_VECTOR_BASE) event_vector_base_r <= reg_wdata;
			if (pc.load) boot_r <= 1'b0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_boot_fetch: assert property (boot_r && pc.load |-> pc.target == RESET_ADDR)
		else $error("boot target wrong");
	a_crit_target: assert property (evt_ack && evt_ack_idx < 4'h4 |-> ##3 pc.load &&
		pc.target == (event_vector_base_r | {18'h0, EV_OFF[$past(evt_ack_idx, 3)]})) else $error("critical target wrong");
	a_irq_target: assert property (evt_ack && irq_ack |-> ##9 pc.load &&
		pc.target == (event_vector_base_r | {18'h0, $past(irq.offset, 10)})) else $error("autovector target wrong");
	a_int_push: assert property (evt_ack && irq_ack |-> ##1 stk.we [*8] ##1 !stk.we)
		else $error("interrupt push count wrong");
	a_exc_push: assert property (evt_ack && !irq_ack |-> ##1 stk.we [*2] ##1 !stk.we)
		else $error("exception push count wrong");
	a_nmi_taken: assert property (!busy && ce && evt.nmi && evt.exc_old == '0 && evt.exc_young == '0 &&
		!ctl.dbg_req && !sr[SR_D] |=> evt_ack && evt_ack_idx == 4'h3) else $error("nmi not taken");
	a_irq_masked: assert property (!busy && sr[SR_GM] |=> !irq_ack) else $error("masked irq taken");
	a_exc_masks: assert property (evt_ack && !irq_ack && evt_ack_idx != 4'h3 |-> ##3 sr[SR_EM] && sr[SR_GM])
		else $error("exception masks not set");
	a_dbg_entry: assert property (!busy && ce && ctl.dbg_req && !sr[SR_DM] && !sr[SR_D] |=>
		pc.load && pc.target == $past(ctl.dbg_addr) && sr[SR_D]) else $error("debug entry wrong");
	c_irq: cover property (evt_ack && irq_ack);
	c_nmi: cover property (evt_ack && evt_ack_idx == 4'h3);
	c_dbg: cover property (pc.load && sr[SR_D]);
endmodule : ceh_top_assertions
bind ceh_top ceh_top_assertions u_chk (.clock, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .evt, .irq, .ctl,
	.evt_ack, .evt_ack_idx, .irq_ack, .busy, .stk, .pc, .sr);
`default_nettype wire

// ===== ceh_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module ceh_top_test;
	import ceh_pkg::*;
	localparam logic [31:0] EVENT_VECTOR_BASE = 32'h0001_0018;
	localparam logic [31:0] SUP = 32'h0040_0000;
	localparam logic [10:0] EXC_SET [4] = '{11'h020, 11'h022, 11'h004, 11'h001};
	localparam logic [31:0] EXC_OFF [4] = '{32'h0000_0020, 32'h0000_0008, 32'h0000_000C, 32'h0000_0000};
	localparam logic [3:0] EXC_IDX [4] = '{4'hA, 4'h1, 4'h2, 4'h0};
	logic clock, arst_n, ce, reg_wr, reg_rd, evt_ack, irq_ack, busy, rd_d;
	logic [4:0] reg_addr;
	logic [3:0] evt_ack_idx, want;
	logic [1:0] irq_ack_lvl;
	logic [2:0] bank_sel;
	logic [31:0] reg_wdata, reg_rdata, stk_rdata, sr;
	logic [31:0] mem [64];
	logic [31:0] sp_m;
	logic [31:0] q_pc[$], q_rd[$];
	ceh_evt_s evt;
	ceh_irq_s irq;
	ceh_ctl_s ctl;
	ceh_ctx_s ctx;
	ceh_stk_s stk;
	ceh_rf_s rf;
	ceh_pc_s pc;
	int failures, n_checks, k;
	int seed = 32'h994F;
	ceh_top uut (.clock(clock), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .irq(irq), .ctl(ctl), .ctx(ctx),
		.evt_ack(evt_ack), .evt_ack_idx(evt_ack_idx), .irq_ack(irq_ack), .irq_ack_lvl(irq_ack_lvl), .busy(busy),
		.stk(stk), .stk_rdata(stk_rdata), .rf(rf), .pc(pc), .sr(sr), .bank_sel(bank_sel));
	ceh_irqc_model u_irqc (.clock(clock), .arst_n(arst_n), .want(want), .irq_ack(irq_ack),
		.irq_ack_lvl(irq_ack_lvl), .irq(irq));
	task automatic end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		if (w) reg_wr <= 1'b1;
		else reg_rd <= 1'b1;
		if (!w) q_rd.push_back(d);
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask : acc
	task automatic idle;
		int i;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (busy !== 1'b0 && i < 60);
		if (busy !== 1'b0) chk(32'h1, 32'h0);
		if (busy !== 1'b0) end_of_test;
	endtask : idle
	task automatic ack(input logic [3:0] idx);
		for (int i = 0; i < 40 && evt_ack !== 1'b1; i++) @(posedge clock);
		chk({27'h0, evt_ack, evt_ack_idx}, {28'h1, idx});
		if (evt_ack !== 1'b1) end_of_test;
	endtask : ack
	task automatic ctlp(input ceh_ctl_s v);
		@(posedge clock);
		ctl <= v;
		@(posedge clock);
		ctl <= '0;
	endtask : ctlp
	task automatic ret(input logic [31:0] s, input logic [31:0] p);
		idle;
		q_pc.push_back(p);
		ctlp(37'h2);
		idle;
		acc(1'b0, REG_SR, s);
	endtask : ret
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		if (pc.load) chk(pc.target, q_pc.size() ? q_pc.pop_front() : 32'hX);
		if (rd_d) chk(reg_rdata, q_rd.size() ? q_rd.pop_front() : 32'hX);
		if (rf.we) chk(rf.data, ctx.regs[rf.idx]);
		if (stk.we) begin
			sp_m = sp_m - 32'h0000_0004;
			chk(stk.addr, sp_m);
			mem[stk.addr[7:2]] = stk.wdata;
		end
		if (stk.re) begin
			chk(stk.addr, sp_m);
			sp_m = sp_m + 32'h0000_0004;
		end
		rd_d = reg_rd;
	end
	// stack memory answers in the cycle of the read strobe
	assign stk_rdata = stk.re ? mem[stk.addr[7:2]] : ~mem[stk.addr[7:2]];
	initial begin
		arst_n = 1'b0;
		ce = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd, rd_d, want} = '0;
		sp_m = 32'h0000_2000;
		evt = '0;
		ctl = '0;
		for (k = 0; k < 8; k++) ctx[k*32+:32] = $random(seed);
		q_pc.push_back(RESET_ADDR);
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		idle;
		acc(1'b1, REG_EVENT_VECTOR_BASE, EVENT_VECTOR_BASE);
		acc(1'b1, REG_SP, 32'h0000_2000);
		acc(1'b0, REG_EVENT_VECTOR_BASE, EVENT_VECTOR_BASE);
		acc(1'b0, 5'h1C, 32'h0);
		acc(1'b0, REG_SR, SR_RST);
		evt.nmi <= 1'b1;
		q_pc.push_back(EVENT_VECTOR_BASE | 32'h10);
		ack(4'h3);
		evt.nmi <= 1'b0;
		ret(SR_RST, ctx.ctx_pc);
		acc(1'b1, REG_SR, SUP);
		for (k = 0; k < 4; k++) begin
			evt.exc_old <= EXC_SET[k];
			evt.exc_young <= (k == 0) ? 11'h001 : 11'h000;
			q_pc.push_back(EVENT_VECTOR_BASE | EXC_OFF[k]);
			ack(EXC_IDX[k]);
			evt <= '0;
			idle;
			acc(1'b0, REG_SR, 32'h01BF_0000);
			ret(SUP, (k == 1 || k == 2) ? ctx.ctx_pc : ctx.off_pc);
		end
		want <= 4'h9;
		@(posedge clock);
		want <= 4'h0;
		q_pc.push_back(EVENT_VECTOR_BASE | 32'h3FFC);
		ack(4'h4);
		chk({30'h0, irq_ack_lvl}, 32'h3);
		idle;
		acc(1'b0, REG_SR, 32'h015E_0000);
		q_pc.push_back(ctx.ctx_pc);
		q_pc.push_back(EVENT_VECTOR_BASE | 32'h0104);
		ctlp(37'h2);
		ack(4'h7);
		idle;
		want <= 4'h4;
		@(posedge clock);
		want <= 4'h0;
		q_pc.push_back(EVENT_VECTOR_BASE | 32'h2104);
		ack(4'h5);
		ret(32'h0082_0000, ctx.ctx_pc);
		ret(SUP, ctx.ctx_pc);
		q_pc.push_back(32'h8000_0400);
		ctlp({1'b1, 32'h8000_0400, 4'h0});
		idle;
		acc(1'b0, REG_DRSR, SUP);
		q_pc.push_back(ctx.ctx_pc);
		ctlp(37'h1);
		idle;
		acc(1'b0, REG_SR, SUP);
		q_pc.push_back(EVENT_VECTOR_BASE | 32'h100);
		ctlp(37'h8);
		idle;
		q_pc.push_back(ctx.ctx_pc + 32'h2);
		ctlp(37'h4);
		idle;
		acc(1'b0, REG_SR, SUP);
		repeat (4) @(posedge clock);
		chk(q_pc.size(), 32'h0);
		chk({29'h0, bank_sel}, {29'h0, MODE_SUP});
		end_of_test;
	end
endmodule : ceh_top_test
`default_nettype wire
